//--- design/ifd_pkg.sv
package ifd_pkg;
  // terminal count and field widths
  localparam int N_TERM = 5;
  localparam int FN_W   = 5;
  localparam int FREQ_W = 16;  // 0.01 Hz units
  localparam int CUR_W  = 16;  // 0.1 A units
  localparam int RPM_W  = 16;

  // terminal function codes
  localparam logic [4:0] FN_FWD   = 5'h00;
  localparam logic [4:0] FN_REV   = 5'h01;
  localparam logic [4:0] FN_PS1   = 5'h02;
  localparam logic [4:0] FN_PS2   = 5'h03;
  localparam logic [4:0] FN_PS4   = 5'h04;
  localparam logic [4:0] FN_JOGF  = 5'h06;
  localparam logic [4:0] FN_JOGR  = 5'h07;
  localparam logic [4:0] FN_UP    = 5'h08;
  localparam logic [4:0] FN_DN    = 5'h09;
  localparam logic [4:0] FN_ACC2  = 5'h0A;
  localparam logic [4:0] FN_HOLD  = 5'h0B;
  localparam logic [4:0] FN_RSRC  = 5'h0C;
  localparam logic [4:0] FN_FSRC  = 5'h0D;
  localparam logic [4:0] FN_RSTOP = 5'h0E;
  localparam logic [4:0] FN_BB    = 5'h0F;
  localparam logic [4:0] FN_FRST  = 5'h11;

  // run modes
  localparam logic [1:0] MODE_2W_A = 2'h0;
  localparam logic [1:0] MODE_2W_B = 2'h1;
  localparam logic [1:0] MODE_3W   = 2'h2;
  localparam logic [4:0] MASK_3W   = 5'h07;

  // register byte offsets
  localparam logic [7:0] REG_TFN0  = 8'h00;
  localparam logic [7:0] REG_CTRL  = 8'h14;
  localparam logic [7:0] REG_STEP  = 8'h18;
  localparam logic [7:0] REG_ULIM  = 8'h1C;
  localparam logic [7:0] REG_FREQ  = 8'h20;
  localparam logic [7:0] REG_STAT  = 8'h24;
  localparam logic [7:0] REG_NLCUR = 8'h28;
  localparam logic [7:0] REG_RCUR  = 8'h2C;
  localparam logic [7:0] REG_SLPCT = 8'h30;
  localparam logic [7:0] REG_RSPD  = 8'h34;
  localparam logic [7:0] REG_POLES = 8'h38;
  localparam logic [7:0] REG_SLIP  = 8'h3C;
  localparam logic [7:0] REG_BOOST = 8'h40;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EXT_MAIN = 2;
  localparam int CTRL_EXT_ALT  = 3;

  // reset values
  localparam logic [3:0]  CTRL_RST  = 4'h4;
  localparam logic [15:0] STEP_RST  = 16'h0064;
  localparam logic [15:0] ULIM_RST  = 16'hFDE8;
  localparam logic [15:0] NLCUR_RST = 16'h0014;
  localparam logic [15:0] RCUR_RST  = 16'h0064;
  localparam logic [15:0] RSPD_RST  = 16'h06B8;
  localparam logic [7:0]  POLES_RST = 8'h04;

  // timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int UD_HOLD_S   = 2;
  localparam int UD_HOLD_CYC = UD_HOLD_S * CLK_HZ;
  localparam int UD_RATE_MS  = 10;
  localparam int UD_RATE_CYC = UD_RATE_MS * (CLK_HZ / 1000);

  // slip arithmetic constants
  localparam int SYNC_K  = 120;
  localparam int CENTI   = 100;
  localparam int PCT_DIV = 1000;  // compensation in 0.1 %

  typedef enum logic {R3_STOP, R3_RUN} ifd_run3_t;
endpackage

//--- design/ifd_decoder.sv
// Notes on behaviour
// - mode 0: fwd/rev terminals run while on
// - mode 0: both fwd and rev means stop
// - mode 1: code 0 runs, code 1 direction
// - 3-wire: terminals 1-3 fixed, codes ignored
// - codes 4,3,2 form preset index msb-lsb
// - index picks own speed and ramp times
// - code 6 jog forward, code 7 reverse
// - both jog inputs give stop
// - code 8 steps up to upper limit
// - code 9 steps down to zero
// - code 10 selects second ramp times
// - code 11 holds output frequency
// - code 12 selects alternative run source
// - code 13 selects alternative frequency source
// - code 14 forces controlled rapid stop
// - code 15 switches power output off
// - slip boost from current ratio formula
// - slip is sync minus rated speed
// - run mode only with external source
// - short hold one step, long hold ramps
// - code 17 resets resettable faults
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int HOLD_CYC = ifd_pkg::UD_HOLD_CYC,
  parameter int RATE_CYC = ifd_pkg::UD_RATE_CYC
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      input_terminal_1,
  input  wire logic                      input_terminal_2,
  input  wire logic                      input_terminal_3,
  input  wire logic                      input_terminal_4,
  input  wire logic                      input_terminal_5,
  input  wire logic [ifd_pkg::CUR_W-1:0] out_current,
  input  wire logic [ifd_pkg::FREQ_W-1:0] out_freq,
  output logic                           run_fwd,
  output logic                           run_rev,
  output logic                           jog_fwd,
  output logic                           jog_rev,
  output logic      [2:0]                preset_index,
  output logic                           ramp2_sel,
  output logic                           ramp_hold,
  output logic                           run_src_alt,
  output logic                           freq_src_alt,
  output logic                           rapid_stop,
  output logic                           output_off,
  output logic                           fault_reset,
  output logic      [ifd_pkg::FREQ_W-1:0] freq_cmd,
  output logic      [ifd_pkg::RPM_W-1:0]  slip_boost
);
  import ifd_pkg::*;

  // configuration registers
  logic [N_TERM-1:0][FN_W-1:0] fn_q;   // function code per terminal
  logic [3:0]        ctrl_q;           // mode and source flags
  logic [15:0]       step_q;           // up/down step
  logic [15:0]       ulim_q;           // upper frequency limit
  logic [15:0]       nlcur_q;          // no-load current
  logic [15:0]       rcur_q;           // rated current
  logic [9:0]        slpct_q;          // compensation, 0.1 %
  logic [15:0]       rspd_q;           // rated speed rpm
  logic [7:0]        poles_q;          // pole count
  // bus state
  logic              wr_q;             // write data phase pending
  logic              rd_q;             // read wait cycle pending
  logic [7:0]        addr_q;           // latched byte address
  logic [31:0]       rdata_q;          // read data flop
  // terminal synchroniser
  logic [N_TERM-1:0] t_s1_q;
  logic [N_TERM-1:0] t_s2_q;
  // decode state
  ifd_run3_t         run3_q;           // 3-wire latch
  logic              up_q, dn_q;       // previous step inputs
  logic              frst_q;           // previous reset input
  logic [31:0]       hold_cnt_q;       // hold time counter
  logic [31:0]       rate_cnt_q;       // repeat counter
  logic [15:0]       freq_q;           // stepped frequency
  logic [15:0]       sync_q, slip_q, boost_q;
  // combinational decode
  logic [N_TERM-1:0] t_eff;
  logic              ext_src, bb, rstop;
  logic              fwd_t, rev_t, rf, rr, jf, jr, up, dn;
  logic              step_now;
  logic [2:0]        pidx;

  // any unmasked terminal carrying this code is on
  function automatic logic fn_on(input logic [N_TERM-1:0] t,
                                 input logic [N_TERM-1:0][FN_W-1:0] c,
                                 input logic [FN_W-1:0] f);
    fn_on = 1'b0;
    for (int i = 0; i < N_TERM; i++) begin
      if (t[i] && c[i] == f) begin
        fn_on = 1'b1;
      end
    end
  endfunction

  // register read mux, shared by bus and nothing else hidden
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < N_TERM; i++) begin
      if (a == REG_TFN0 + 8'(4 * i)) begin
        rd_mux = {27'h0, fn_q[i]};
      end
    end
    unique case (a)
      REG_CTRL:  rd_mux = {28'h0, ctrl_q};
      REG_STEP:  rd_mux = {16'h0, step_q};
      REG_ULIM:  rd_mux = {16'h0, ulim_q};
      REG_FREQ:  rd_mux = {16'h0, freq_q};
      REG_STAT:  rd_mux = {14'h0, t_s2_q, output_off, rapid_stop,
                           freq_src_alt, run_src_alt, ramp_hold,
                           ramp2_sel, preset_index, jog_rev, jog_fwd,
                           run_rev, run_fwd};
      REG_NLCUR: rd_mux = {16'h0, nlcur_q};
      REG_RCUR:  rd_mux = {16'h0, rcur_q};
      REG_SLPCT: rd_mux = {22'h0, slpct_q};
      REG_RSPD:  rd_mux = {16'h0, rspd_q};
      REG_POLES: rd_mux = {24'h0, poles_q};
      REG_SLIP:  rd_mux = {16'h0, slip_q};
      REG_BOOST: rd_mux = {16'h0, boost_q};
      default:   ;  // unmapped or terminal codes handled above
    endcase
  endfunction

  // bus phase tracking; reads take one wait so data is fresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr[7:0];
    end else begin
      rd_q   <= 1'b0;
    end
  end

  // read data is captured during the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      rdata_q <= rd_mux(addr_q);
    end
  end

  assign hreadyout = !rd_q;
  assign hresp     = 1'b0;  // always OKAY
  assign hrdata    = rdata_q;

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_q    <= '0;
      ctrl_q  <= CTRL_RST;
      step_q  <= STEP_RST;
      ulim_q  <= ULIM_RST;
      nlcur_q <= NLCUR_RST;
      rcur_q  <= RCUR_RST;
      slpct_q <= '0;
      rspd_q  <= RSPD_RST;
      poles_q <= POLES_RST;
    end else if (wr_q) begin
      for (int i = 0; i < N_TERM; i++) begin
        if (addr_q == REG_TFN0 + 8'(4 * i)) begin
          fn_q[i] <= hwdata[FN_W-1:0];
        end
      end
      unique case (addr_q)
        REG_CTRL:  ctrl_q  <= hwdata[3:0];
        REG_STEP:  step_q  <= hwdata[15:0];
        REG_ULIM:  ulim_q  <= hwdata[15:0];
        REG_NLCUR: nlcur_q <= hwdata[15:0];
        REG_RCUR:  rcur_q  <= hwdata[15:0];
        REG_SLPCT: slpct_q <= hwdata[9:0];
        REG_RSPD:  rspd_q  <= hwdata[15:0];
        REG_POLES: poles_q <= hwdata[7:0];
        default:   ;  // read-only, unmapped or terminal codes handled above
      endcase
    end
  end

  // two-flop synchroniser on the terminal pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_s1_q <= '0;
      t_s2_q <= '0;
    end else begin
      t_s1_q <= {input_terminal_5, input_terminal_4, input_terminal_3,
                 input_terminal_2, input_terminal_1};
      t_s2_q <= t_s1_q;
    end
  end

  // terminal decode
  always_comb begin
    // fixed 3-wire terminals hide their codes
    t_eff = (ctrl_q[1:0] == MODE_3W) ? (t_s2_q & ~MASK_3W) : t_s2_q;
    bb    = fn_on(t_eff, fn_q, FN_BB);
    rstop = fn_on(t_eff, fn_q, FN_RSTOP);
    ext_src = fn_on(t_eff, fn_q, FN_RSRC) ? ctrl_q[CTRL_EXT_ALT]
                                          : ctrl_q[CTRL_EXT_MAIN];
    fwd_t = fn_on(t_eff, fn_q, FN_FWD);
    rev_t = fn_on(t_eff, fn_q, FN_REV);
    unique case (ctrl_q[1:0])
      MODE_2W_A: begin
        rf = fwd_t && !rev_t;
        rr = rev_t && !fwd_t;
      end
      MODE_2W_B: begin
        rf = fwd_t && !rev_t;
        rr = fwd_t && rev_t;
      end
      MODE_3W: begin
        rf = (run3_q == R3_RUN) && !t_s2_q[2];
        rr = (run3_q == R3_RUN) && t_s2_q[2];
      end
      default: begin
        rf = 1'b0;
        rr = 1'b0;
      end
    endcase
    // no terminal run unless terminals own the run source
    if (!ext_src || bb || rstop) begin
      rf = 1'b0;
      rr = 1'b0;
    end
    jf = fn_on(t_eff, fn_q, FN_JOGF) && !fn_on(t_eff, fn_q, FN_JOGR)
         && !bb;
    jr = fn_on(t_eff, fn_q, FN_JOGR) && !fn_on(t_eff, fn_q, FN_JOGF)
         && !bb;
    // unassigned codes simply never match, so bits read zero
    pidx = {fn_on(t_eff, fn_q, FN_PS4), fn_on(t_eff, fn_q, FN_PS2),
            fn_on(t_eff, fn_q, FN_PS1)};
    up = fn_on(t_eff, fn_q, FN_UP) && !fn_on(t_eff, fn_q, FN_DN) && !bb;
    dn = fn_on(t_eff, fn_q, FN_DN) && !fn_on(t_eff, fn_q, FN_UP) && !bb;
  end

  // 3-wire latch; stop button wins over run button
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run3_q <= R3_STOP;
    end else if (ctrl_q[1:0] != MODE_3W || t_s2_q[1] || bb) begin
      run3_q <= R3_STOP;
    end else if (t_s2_q[0]) begin
      run3_q <= R3_RUN;
    end
  end

  // registered command outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_fwd      <= 1'b0;
      run_rev      <= 1'b0;
      jog_fwd      <= 1'b0;
      jog_rev      <= 1'b0;
      preset_index <= 3'h0;
      ramp2_sel    <= 1'b0;
      ramp_hold    <= 1'b0;
      run_src_alt  <= 1'b0;
      freq_src_alt <= 1'b0;
      rapid_stop   <= 1'b0;
      output_off   <= 1'b0;
      fault_reset  <= 1'b0;
      frst_q       <= 1'b0;
    end else begin
      run_fwd      <= rf;
      run_rev      <= rr;
      jog_fwd      <= jf;
      jog_rev      <= jr;
      // the index addresses the external speed and ramp table
      preset_index <= pidx;
      ramp2_sel    <= fn_on(t_eff, fn_q, FN_ACC2);
      ramp_hold    <= fn_on(t_eff, fn_q, FN_HOLD);
      run_src_alt  <= fn_on(t_eff, fn_q, FN_RSRC);
      freq_src_alt <= fn_on(t_eff, fn_q, FN_FSRC);
      rapid_stop   <= rstop;
      output_off   <= bb;
      frst_q       <= fn_on(t_eff, fn_q, FN_FRST);
      // one pulse per activation, like the panel key
      fault_reset  <= fn_on(t_eff, fn_q, FN_FRST) && !frst_q;
    end
  end

  // step timing: one step on press, repeats after the long hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_q       <= 1'b0;
      dn_q       <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
      rate_cnt_q <= 32'h0000_0000;
    end else begin
      up_q <= up;
      dn_q <= dn;
      if (!(up || dn) || (up && !up_q) || (dn && !dn_q)) begin
        hold_cnt_q <= 32'h0000_0000;
        rate_cnt_q <= 32'h0000_0000;
      end else if (hold_cnt_q < 32'(HOLD_CYC)) begin
        hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
      end else if (rate_cnt_q == 32'(RATE_CYC - 1)) begin
        rate_cnt_q <= 32'h0000_0000;
      end else begin
        rate_cnt_q <= rate_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign step_now = (up && !up_q) || (dn && !dn_q) ||
                    ((up || dn) && hold_cnt_q == 32'(HOLD_CYC) &&
                     rate_cnt_q == 32'(RATE_CYC - 1));

  // frequency stepping, clamped at the limit and at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_q <= 16'h0000;
    end else if (step_now && up) begin
      freq_q <= (17'(freq_q) + 17'(step_q) > 17'(ulim_q)) ? ulim_q
                : freq_q + step_q;
    end else if (step_now && dn) begin
      freq_q <= (freq_q < step_q) ? 16'h0000 : freq_q - step_q;
    end
  end

  assign freq_cmd = freq_q;

  // slip arithmetic, one pipeline stage per term
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q  <= 16'h0000;
      slip_q  <= 16'h0000;
      boost_q <= 16'h0000;
    end else begin
      sync_q <= (poles_q == 8'h00) ? 16'h0000 :
        16'((SYNC_K * 32'(out_freq)) / (CENTI * 32'(poles_q)));
      slip_q <= (sync_q > rspd_q) ? sync_q - rspd_q : 16'h0000;
      // below no-load current or a bad rating gives no boost
      boost_q <= (out_current <= nlcur_q || rcur_q <= nlcur_q) ? 16'h0000 :
        16'((64'(out_current - nlcur_q) * 64'(slpct_q) * 64'(slip_q)) /
            (64'(rcur_q - nlcur_q) * 64'(PCT_DIV)));
    end
  end

  assign slip_boost = boost_q;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_long_up;
    up && up_q && hold_cnt_q == 32'(HOLD_CYC);
  endsequence

  property p_fwd_rev_stop;
    ctrl_q[1:0] == MODE_2W_A && fwd_t && rev_t |=> !run_fwd && !run_rev;
  endproperty
  a_fwd_rev_stop: assert property (p_fwd_rev_stop)
    else $error("both directions did not stop");

  property p_mode_b_dir;
    ctrl_q[1:0] == MODE_2W_B && ext_src && !bb && !rstop && fwd_t
    |=> run_rev == $past(rev_t) && run_fwd == !$past(rev_t);
  endproperty
  a_mode_b_dir: assert property (p_mode_b_dir)
    else $error("direction select wrong");

  property p_jog_both;
    fn_on(t_eff, fn_q, FN_JOGF) && fn_on(t_eff, fn_q, FN_JOGR)
    |=> !jog_fwd && !jog_rev;
  endproperty
  a_jog_both: assert property (p_jog_both)
    else $error("jog with both inputs");

  property p_bb_over;
    bb |=> output_off && !run_fwd && !run_rev && !jog_fwd && !jog_rev;
  endproperty
  a_bb_over: assert property (p_bb_over)
    else $error("base block not dominant");

  property p_no_ext;
    !ext_src |=> !run_fwd && !run_rev;
  endproperty
  a_no_ext: assert property (p_no_ext)
    else $error("run without external source");

  property p_up_clamp;
    freq_q <= ulim_q && step_now && up |=> freq_q <= ulim_q;
  endproperty
  a_up_clamp: assert property (p_up_clamp)
    else $error("upper limit exceeded");

  property p_dn_step;
    step_now && dn |=> freq_q == ($past(freq_q) < $past(step_q) ? 16'h0000
                       : $past(freq_q) - $past(step_q));
  endproperty
  a_dn_step: assert property (p_dn_step)
    else $error("down step wrong");

  property p_short_one;
    up && !up_q ##1 (up && hold_cnt_q < 32'(HOLD_CYC))[*2] |-> !step_now;
  endproperty
  a_short_one: assert property (p_short_one)
    else $error("extra step before long hold");

  property p_long_rep;
    s_long_up and rate_cnt_q == 32'(RATE_CYC - 1) |=> $changed(freq_q)
      || $past(freq_q) == ulim_q;
  endproperty
  a_long_rep: assert property (p_long_rep)
    else $error("long hold did not repeat");

  property p_reset_pulse;
    fault_reset |=> !fault_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("fault reset not a pulse");

  property p_preset;
    1'b1 |=> preset_index == {$past(fn_on(t_eff, fn_q, FN_PS4)),
      $past(fn_on(t_eff, fn_q, FN_PS2)), $past(fn_on(t_eff, fn_q, FN_PS1))};
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset index mismatch");

endmodule  // ifd_decoder

//--- tb/ifd_switches.sv
// switches and push buttons wired to the five input terminals
module ifd_switches (
  input  wire logic       hclk,
  input  wire logic [4:0] press,
  output logic            input_terminal_1,
  output logic            input_terminal_2,
  output logic            input_terminal_3,
  output logic            input_terminal_4,
  output logic            input_terminal_5
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] contact_q = 5'h00;  // contacts open at power up
  // contacts take the press value on each rising clock edge, one cycle behind it
  always @(posedge hclk) begin
    contact_q <= press;
  end
  assign input_terminal_1 = contact_q[0];
  assign input_terminal_2 = contact_q[1];
  assign input_terminal_3 = contact_q[2];
  assign input_terminal_4 = contact_q[3];
  assign input_terminal_5 = contact_q[4];
endmodule // ifd_switches

//--- tb/inverter_input_function_decoder_test.sv
module inverter_input_function_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ifd_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, preset_index;
  logic [4:0]  press;     // wanted switch positions, bit 0 is terminal 1
  wire  [4:0]  t;
  logic [15:0] out_current, out_freq, freq_cmd, slip_boost;
  logic        run_fwd, run_rev, jog_fwd, jog_rev, ramp2_sel, ramp_hold;
  logic        run_src_alt, freq_src_alt, rapid_stop, output_off;
  logic        fault_reset;
  int          bad_count, n_checks, cyc, fr_cnt;
  // short hold and repeat counts keep the up/down tests brief
  ifd_decoder #(.HOLD_CYC(20), .RATE_CYC(4)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .input_terminal_1(t[0]), .input_terminal_2(t[1]),
    .input_terminal_3(t[2]), .input_terminal_4(t[3]),
    .input_terminal_5(t[4]), .out_current(out_current),
    .out_freq(out_freq), .run_fwd(run_fwd), .run_rev(run_rev),
    .jog_fwd(jog_fwd), .jog_rev(jog_rev), .preset_index(preset_index),
    .ramp2_sel(ramp2_sel), .ramp_hold(ramp_hold),
    .run_src_alt(run_src_alt), .freq_src_alt(freq_src_alt),
    .rapid_stop(rapid_stop), .output_off(output_off),
    .fault_reset(fault_reset), .freq_cmd(freq_cmd),
    .slip_boost(slip_boost));
  ifd_switches sw_u (.hclk(hclk), .press(press), .input_terminal_1(t[0]),
    .input_terminal_2(t[1]), .input_terminal_3(t[2]),
    .input_terminal_4(t[3]), .input_terminal_5(t[4]));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // cycle ceiling and fault pulse counter
  always @(posedge hclk) begin
    cyc++;
    if (fault_reset === 1'b1) fr_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // hready is looked at mid-cycle, where it has long settled for the edge
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy(q);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
    chk("resp", {31'h0, hresp}, 32'h0);
  endtask
  // five function codes, terminal 5 in the top field
  task automatic fns(input logic [24:0] c);
    for (int i = 0; i < 5; i++) wr(8'(4 * i), {27'h0, c[5*i+:5]});
  endtask
  // three edges through the decoder plus one in the switch model
  task automatic pins(input logic [4:0] p);
    press <= p;
    repeat (6) @(posedge hclk);
  endtask
  // all four states of terminals 1 and 2
  task automatic quad(input bit j, input logic [3:0] ef, input logic [3:0] er);
    for (int i = 0; i < 4; i++) begin
      pins(5'(i));
      chk("fwd", j ? jog_fwd : run_fwd, {31'h0, ef[i]});
      chk("rev", j ? jog_rev : run_rev, {31'h0, er[i]});
    end
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = '0; hwdata = '0; press = '0; out_current = '0; out_freq = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_CTRL, 32'h4, "ctrl");
    rd(REG_POLES, 32'h4, "poles");
    wr(8'h80, 32'h5A);
    rd(8'h80, 32'h0, "hole");
    $display("test registers done");
    fns({FN_HOLD, FN_HOLD, FN_HOLD, FN_REV, FN_FWD});
    quad(1'b0, 4'b0010, 4'b0100);
    pins(5'h01);
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge hclk);
    chk("no ext", run_fwd, 32'h0);
    wr(REG_CTRL, 32'h5);
    quad(1'b0, 4'b0010, 4'b1000);
    fns({FN_HOLD, FN_HOLD, FN_JOGF, FN_JOGF, FN_JOGF});
    wr(REG_CTRL, 32'h6);
    pins(5'h01);
    pins(5'h00);
    chk("3w run", run_fwd, 32'h1);
    chk("3w jog", jog_fwd, 32'h0);
    pins(5'h04);
    chk("3w dir", run_rev, 32'h1);
    pins(5'h06);
    chk("3w stop", run_rev, 32'h0);
    wr(REG_CTRL, 32'h4);
    fns({FN_HOLD, FN_HOLD, FN_HOLD, FN_JOGR, FN_JOGF});
    quad(1'b1, 4'b0010, 4'b0100);
    $display("test run modes done");
    // terminals 3, 4, 5 carry the high, middle and low index bits
    fns({FN_PS1, FN_PS2, FN_PS4, FN_HOLD, FN_ACC2});
    for (int i = 0; i < 8; i++) begin
      pins({i[0], i[1], i[2], 2'b00});
      chk("index", preset_index, 32'(i));
    end
    pins(5'h03);
    chk("ramp2", ramp2_sel, 32'h1);
    chk("hold", ramp_hold, 32'h1);
    // status word: synced pins 1 and 2, hold and second ramp set
    rd(REG_STAT, 32'h6180, "stat");
    wr(8'h08, {27'h0, FN_FSRC});
    pins(5'h1C);
    chk("lost bit", preset_index, 32'h3);
    chk("fsrc", freq_src_alt, 32'h1);
    chk("ramp1", ramp2_sel, 32'h0);
    // open all contacts first so new codes fire no stray pulse or step
    pins(5'h00);
    fns({FN_FRST, FN_RSTOP, FN_BB, FN_RSRC, FN_FWD});
    pins(5'h03);
    chk("rsrc", run_src_alt, 32'h1);
    chk("alt run", run_fwd, 32'h0);
    pins(5'h05);
    chk("off", output_off, 32'h1);
    chk("bb run", run_fwd, 32'h0);
    pins(5'h09);
    chk("rapid", {rapid_stop, run_fwd}, 32'h2);
    pins(5'h11);
    chk("run", run_fwd, 32'h1);
    chk("fault", fr_cnt, 32'h1);
    $display("test functions done");
    pins(5'h00);
    fns({FN_HOLD, FN_HOLD, FN_BB, FN_DN, FN_UP});
    wr(REG_ULIM, 32'h190);
    pins(5'h01);
    pins(5'h00);
    chk("up one", freq_cmd, 32'h64);
    rd(REG_FREQ, 32'h64, "freq reg");
    for (int i = 0; i < 2; i++) begin
      pins(5'h02);
      pins(5'h00);
      chk("down", freq_cmd, 32'h0);
    end
    pins(5'h05);
    chk("bb up", freq_cmd, 32'h0);
    pins(5'h00);
    press <= 5'h01;
    repeat (60) @(posedge hclk);
    chk("up long", freq_cmd, 32'h190);
    press <= 5'h02;
    repeat (80) @(posedge hclk);
    chk("dn long", freq_cmd, 32'h0);
    pins(5'h00);
    $display("test stepping done");
    // 60 Hz on four poles is 1800 rpm, less 1720 rated gives 80 slip
    out_freq <= 16'h1770;
    out_current <= 16'h003C;
    wr(REG_SLPCT, 32'h3E8);
    repeat (6) @(posedge hclk);
    rd(REG_SLIP, 32'h50, "slip");
    chk("boost", slip_boost, 32'h28);
    wr(REG_SLPCT, 32'h1F4);
    repeat (6) @(posedge hclk);
    chk("boost half", slip_boost, 32'h14);
    $display("test slip done");
    test_done;
  end
endmodule // inverter_input_function_decoder_test
